// File: licc_charger.sv
// Lithium-ion linear charger control core
`timescale 1ns/1ps
`default_nettype none
module licc_charger (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata_ff,
  // Analog comparator inputs (asynchronous)
  input wire logic input_power_good,
  input wire logic bat_above_short,
  input wire logic bat_above_low,
  input wire logic bat_above_recharge,
  input wire logic bat_at_regulation,
  input wire logic cur_below_term,
  input wire logic ts_in_window,
  input wire logic ts_above_disable,
  input wire logic die_above_reg,
  input wire logic die_above_off,
  input wire logic die_below_off_hys,
  input wire logic sharing_limit,
  input wire logic vin_low_limit,
  // Measured charge fraction from current loop, 64 means no reduction
  input wire logic [6:0] delivered_frac,
  // Analog control outputs
  output logic [7:0] charge_cur_target_ff,
  output logic [7:0] term_cur_target_ff,
  output logic short_test_src_ff,
  output logic det_sink_en_ff,
  output logic det_src_en_ff,
  output logic cv_mode_ff,
  output logic input_path_switch_ff,
  output logic battery_path_switch_ff,
  output logic ntc_bias_en_ff,
  output logic [1:0] pack_temp_limit_shift_ff,
  output logic charging_active_flag_ff,
  output logic charger_fault_flag_ff
);
  logic [7:0] cfg_one_ff;
  logic [9:0] tmr_cfg_ff;
  logic [12:0] pins;
  logic power_good;
  logic above_short;
  logic above_low;
  logic above_rch;
  logic at_reg;
  logic below_term;
  logic ts_ok;
  logic ts_open;
  logic hot_reg;
  logic hot_off;
  logic cooled;
  logic share_lim;
  logic vin_lim;
  logic power_good_d_ff;
  licc_pkg::licc_state_e state_ff;
  licc_pkg::licc_state_e nxt_state;
  logic [15:0] det_cnt_ff;
  logic det_done;
  logic det_recharge_ff;
  logic active_lock_ff;
  logic therm_off_ff;
  logic ts_monitor;
  logic suspend;
  logic [1:0] scale_sel;
  logic [1:0] pre_sel;
  logic [1:0] term_sel;
  logic charge_en;
  logic term_en;
  logic [7:0] full_cur;
  logic [7:0] timer_rate;
  logic [8:0] dyn_rate;
  logic pre_expired;
  logic fast_expired;
  logic in_phase;

  licc_sync #(
    .W(13)
  ) u_sync (
    .clk(clk),
    .nrst(nrst),
    .d({input_power_good, bat_above_short, bat_above_low, bat_above_recharge,
        bat_at_regulation, cur_below_term, ts_in_window, ts_above_disable,
        die_above_reg, die_above_off, die_below_off_hys, sharing_limit,
        vin_low_limit}),
    .q(pins)
  );

  assign {power_good, above_short, above_low, above_rch, at_reg, below_term, ts_ok,
          ts_open, hot_reg, hot_off, cooled, share_lim, vin_lim} = pins;

  assign charge_en = cfg_one_ff[licc_pkg::EN_BIT];
  assign term_en = cfg_one_ff[licc_pkg::TERM_EN_BIT];
  assign scale_sel = cfg_one_ff[licc_pkg::SCALE_LSB +: 2];
  assign pre_sel = cfg_one_ff[licc_pkg::PRE_LSB +: 2];
  assign term_sel = cfg_one_ff[licc_pkg::TERM_LSB +: 2];

  // Register writes
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cfg_one_ff <= licc_pkg::CFG_ONE_RST;
      tmr_cfg_ff <= licc_pkg::TMR_CFG_RST;
    end
    else if (reg_wr)
    begin
      if (reg_addr == licc_pkg::CFG_ONE_OFS)
      begin
        cfg_one_ff <= reg_wdata[7:0];
      end
      if (reg_addr == licc_pkg::TMR_CFG_OFS)
      begin
        tmr_cfg_ff <= reg_wdata[9:0];
      end
    end
  end

  // Register reads, data in the next cycle only
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      reg_rdata_ff <= 16'h0000;
    end
    else if (reg_rd)
    begin
      case (reg_addr)
        licc_pkg::CFG_ONE_OFS: reg_rdata_ff <= {8'h00, cfg_one_ff};
        licc_pkg::TMR_CFG_OFS: reg_rdata_ff <= {6'h00, tmr_cfg_ff};
        licc_pkg::STATUS_OFS: reg_rdata_ff <= {8'h00, therm_off_ff, suspend,
          4'(state_ff), charger_fault_flag_ff, charging_active_flag_ff};
        licc_pkg::CUR_OFS: reg_rdata_ff <= {term_cur_target_ff, charge_cur_target_ff};
        default: reg_rdata_ff <= 16'h0000;
      endcase
    end
    else
    begin
      reg_rdata_ff <= 16'h0000;
    end
  end

  // Full current, in 1/128 of set resistor current
  always_comb
  begin
    case (scale_sel)
      2'b00: full_cur = 8'h20;
      2'b01: full_cur = 8'h40;
      2'b10: full_cur = 8'h60;
      default: full_cur = 8'h80;
    endcase
  end

  // timer speed from scale; pre-charge field not used
  always_comb
  begin
    case (scale_sel)
      2'b00: timer_rate = 8'h20;
      2'b01: timer_rate = 8'h40;
      2'b10: timer_rate = 8'h60;
      default: timer_rate = 8'h80;
    endcase
    // slow fast-charge timer by delivered fraction, in ST_FAST only
    dyn_rate = 9'(({8'h00, timer_rate} * {9'h000, delivered_frac}) >> 6);
    if (state_ff != licc_pkg::ST_FAST)
    begin
      dyn_rate = {1'b0, timer_rate};
    end
  end

  // thermistor ignored when open and termination off
  assign ts_monitor = !(!term_en && ts_open);
  // suspend on thermistor out of window
  assign suspend = in_phase && ts_monitor && !ts_ok;
  assign in_phase = (state_ff == licc_pkg::ST_PRE) || (state_ff == licc_pkg::ST_FAST) ||
                    (state_ff == licc_pkg::ST_CV);

  // timers run only with termination on; frozen on suspend
  licc_rate_timer u_pre_tmr (
    .clk(clk),
    .nrst(nrst),
    .clear(state_ff != licc_pkg::ST_PRE),
    .run(term_en && !suspend),
    .rate(dyn_rate[7:0]),
    .limit({12'h000, tmr_cfg_ff[licc_pkg::PRE_TMR_LSB +: 4]} << 10),
    .expired(pre_expired)
  );

  licc_rate_timer u_fast_tmr (
    .clk(clk),
    .nrst(nrst),
    .clear(!(state_ff == licc_pkg::ST_FAST || state_ff == licc_pkg::ST_CV)),
    .run(term_en && !suspend),
    .rate(dyn_rate[7:0]),
    .limit({12'h000, tmr_cfg_ff[licc_pkg::FAST_TMR_LSB +: 4]} << 12),
    .expired(fast_expired)
  );

  assign det_done = det_cnt_ff == 16'(licc_pkg::DET_CYCLES - 1);

  // Detection interval counter, restarts on each state change
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      det_cnt_ff <= 16'h0000;
    end
    else if (nxt_state != state_ff || det_done)
    begin
      det_cnt_ff <= 16'h0000;
    end
    else
    begin
      det_cnt_ff <= det_cnt_ff + 16'h1;
    end
  end

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      licc_pkg::ST_IDLE:
      begin
        if (charge_en && power_good)
        begin
          nxt_state = licc_pkg::ST_SHORT;
        end
      end
      licc_pkg::ST_SHORT:
      begin
        if (above_short)
        begin
          nxt_state = licc_pkg::ST_PRE;
        end
      end
      licc_pkg::ST_PRE:
      begin
        if (above_low)
        begin
          nxt_state = licc_pkg::ST_FAST;
        end
        else if (pre_expired)
        begin
          nxt_state = licc_pkg::ST_FAULT;
        end
      end
      licc_pkg::ST_FAST:
      begin
        if (at_reg)
        begin
          nxt_state = licc_pkg::ST_CV;
        end
        else if (fast_expired)
        begin
          nxt_state = licc_pkg::ST_FAULT;
        end
      end
      licc_pkg::ST_CV:
      begin
        // no termination: stay in constant voltage
        if (term_en && below_term && !suspend)
        begin
          nxt_state = licc_pkg::ST_DONE;
        end
        else if (fast_expired)
        begin
          nxt_state = licc_pkg::ST_FAULT;
        end
      end
      licc_pkg::ST_DONE:
      begin
        if (!above_rch)
        begin
          nxt_state = licc_pkg::ST_RM_TEST;
        end
      end
      licc_pkg::ST_RM_TEST:
      begin
        if (!above_low)
        begin
          nxt_state = licc_pkg::ST_INS_SRC;
        end
        else if (det_done)
        begin
          nxt_state = charge_en ? licc_pkg::ST_PRE : licc_pkg::ST_DONE;
        end
      end
      licc_pkg::ST_INS_SRC:
      begin
        if (above_rch)
        begin
          nxt_state = licc_pkg::ST_INS_SINK;
        end
        else if (det_done)
        begin
          nxt_state = licc_pkg::ST_IDLE;
        end
      end
      licc_pkg::ST_INS_SINK:
      begin
        if (!above_low)
        begin
          nxt_state = licc_pkg::ST_INS_SRC;
        end
        else if (det_done)
        begin
          nxt_state = licc_pkg::ST_DONE;
        end
      end
      licc_pkg::ST_FAULT:
      begin
        if (!charge_en)
        begin
          nxt_state = licc_pkg::ST_IDLE;
        end
      end
      default: nxt_state = licc_pkg::ST_IDLE;
    endcase
    if (!charge_en && state_ff != licc_pkg::ST_FAULT && state_ff != licc_pkg::ST_DONE)
    begin
      nxt_state = licc_pkg::ST_IDLE;
    end
    if (!power_good)
    begin
      nxt_state = licc_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_ff <= licc_pkg::ST_IDLE;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // mark cycles started by detection logic
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      det_recharge_ff <= 1'b0;
    end
    else if (state_ff == licc_pkg::ST_RM_TEST && nxt_state == licc_pkg::ST_PRE)
    begin
      det_recharge_ff <= 1'b1;
    end
    else if (state_ff == licc_pkg::ST_IDLE)
    begin
      det_recharge_ff <= 1'b0;
    end
  end

  // latch clear of active until input repowered
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      active_lock_ff <= 1'b0;
      power_good_d_ff <= 1'b0;
    end
    else
    begin
      power_good_d_ff <= power_good;
      if (power_good && !power_good_d_ff)
      begin
        active_lock_ff <= 1'b0;
      end
      else if (!term_en && state_ff == licc_pkg::ST_CV && below_term)
      begin
        active_lock_ff <= 1'b1;
      end
    end
  end

  // active held during suspend; not for detection recharges
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      charging_active_flag_ff <= 1'b0;
      charger_fault_flag_ff <= 1'b0;
    end
    else
    begin
      charging_active_flag_ff <= in_phase && !det_recharge_ff && !active_lock_ff;
      charger_fault_flag_ff <= nxt_state == licc_pkg::ST_FAULT;
    end
  end

  // shutdown opens input path, battery feeds system
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      therm_off_ff <= 1'b0;
    end
    else if (hot_off)
    begin
      therm_off_ff <= 1'b1;
    end
    else if (cooled)
    begin
      therm_off_ff <= 1'b0;
    end
  end

  // Current targets and analog controls
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      charge_cur_target_ff <= 8'h00;
      term_cur_target_ff <= 8'h00;
      short_test_src_ff <= 1'b0;
      det_sink_en_ff <= 1'b0;
      det_src_en_ff <= 1'b0;
      cv_mode_ff <= 1'b0;
      input_path_switch_ff <= 1'b0;
      battery_path_switch_ff <= 1'b0;
      ntc_bias_en_ff <= 1'b0;
      pack_temp_limit_shift_ff <= 2'b00;
    end
    else
    begin
      // unscaled termination threshold, 3.125 to 12.5 percent of full current
      term_cur_target_ff <= 8'(({8'h00, full_cur} * ({14'h0000, term_sel} + 16'h0001)) >> 5);
      if (suspend || therm_off_ff || !in_phase)
      begin
        charge_cur_target_ff <= 8'h00;
      end
      else if (state_ff == licc_pkg::ST_PRE)
      begin
        // fraction of fast current; halved on sharing or die temperature limit
        charge_cur_target_ff <= (share_lim || hot_reg) ?
          8'(({8'h00, full_cur} * ({14'h0000, pre_sel} + 16'h0001)) >> 4) :
          8'(({8'h00, full_cur} * ({14'h0000, pre_sel} + 16'h0001)) >> 3);
      end
      else
      begin
        charge_cur_target_ff <= (hot_reg || vin_lim) ? (full_cur >> 1) : full_cur;
      end
      short_test_src_ff <= state_ff == licc_pkg::ST_SHORT;
      det_sink_en_ff <= state_ff == licc_pkg::ST_RM_TEST ||
                        state_ff == licc_pkg::ST_INS_SINK;
      det_src_en_ff <= state_ff == licc_pkg::ST_INS_SRC;
      cv_mode_ff <= state_ff == licc_pkg::ST_CV;
      input_path_switch_ff <= power_good && !therm_off_ff;
      battery_path_switch_ff <= !power_good || therm_off_ff ||
                                state_ff == licc_pkg::ST_INS_SRC;
      ntc_bias_en_ff <= in_phase && ts_monitor;
      pack_temp_limit_shift_ff <= tmr_cfg_ff[licc_pkg::SHIFT_LSB +: 2];
    end
  end
endmodule
`default_nettype wire

// File: licc_monitor.sv
// Port checker for the charge controller
`timescale 1ns/1ps
`default_nettype none
module licc_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata_ff,
  // Analog side
  input wire logic die_above_off,
  input wire logic [7:0] term_cur_target_ff,
  input wire logic short_test_src_ff,
  input wire logic det_sink_en_ff,
  input wire logic det_src_en_ff,
  input wire logic cv_mode_ff,
  input wire logic input_path_switch_ff,
  input wire logic battery_path_switch_ff,
  input wire logic [1:0] pack_temp_limit_shift_ff,
  input wire logic charging_active_flag_ff
);
  logic [3:0] wr_age_ff;
  logic [1:0] shift_exp_ff;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Cycles since last write, and last shift written
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_age_ff <= 4'h0;
      shift_exp_ff <= licc_pkg::TMR_CFG_RST[9:8];
    end
    else if (reg_wr)
    begin
      wr_age_ff <= 4'h0;
      if (reg_addr == licc_pkg::TMR_CFG_OFS)
        shift_exp_ff <= reg_wdata[9:8];
    end
    else if (wr_age_ff != 4'hF)
      wr_age_ff <= wr_age_ff + 4'h1;
  end
  a_read_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata_ff == 16'h0000)
    else $error("read data not zero outside read slot");
  a_term_unscaled: assert property ($changed(term_cur_target_ff) |-> wr_age_ff < 4'h8)
    else $error("termination target moved without a write");
  a_thermal_off: assert property (die_above_off [*6] |-> !input_path_switch_ff && battery_path_switch_ff)
    else $error("switches wrong at shutdown temperature");
  a_det_exclusive: assert property (!(det_sink_en_ff && det_src_en_ff))
    else $error("sink and source together");
  a_det_quiet_flag: assert property (det_sink_en_ff || det_src_en_ff |-> !charging_active_flag_ff)
    else $error("active flag during detection");
  a_sink_hold: assert property ($rose(det_sink_en_ff) |-> det_sink_en_ff [*8])
    else $error("detection sink too short");
  a_shift_follow: assert property ($changed(pack_temp_limit_shift_ff) |-> wr_age_ff < 4'h4 && pack_temp_limit_shift_ff == shift_exp_ff)
    else $error("temperature shift not as written");
  a_cv_no_det: assert property (cv_mode_ff |-> !det_sink_en_ff && !det_src_en_ff)
    else $error("detection during constant voltage");
  a_short_alone: assert property (short_test_src_ff |-> !det_src_en_ff && !det_sink_en_ff && !cv_mode_ff)
    else $error("short test overlaps other phase");
  c_short: cover property ($rose(short_test_src_ff));
  c_sink: cover property ($rose(det_sink_en_ff));
  c_off: cover property ($fell(input_path_switch_ff));
endmodule
`default_nettype wire

// File: licc_pack_model.sv
// Battery pack and thermistor model facing the charger
`timescale 1ns/1ps
`default_nettype none
module licc_pack_model #(
  parameter int LAG_NS = 2
) (
  // Scenario controls
  input wire logic present,
  input wire logic [2:0] vlvl,
  input wire logic taper,
  input wire logic ts_ok,
  input wire logic ts_open,
  // Charger drive
  input wire logic det_sink_en,
  input wire logic det_src_en,
  // Comparator levels
  output logic bat_above_short,
  output logic bat_above_low,
  output logic bat_above_recharge,
  output logic bat_at_regulation,
  output logic cur_below_term,
  output logic ts_in_window,
  output logic ts_above_disable
);
  logic [2:0] lvl;
  // Empty pin: sink pulls it down, source pulls it up
  assign lvl = present ? vlvl : (det_src_en ? 3'h3 : 3'h0);
  assign #(LAG_NS) bat_above_short = lvl >= 3'h1;
  assign #(LAG_NS) bat_above_low = lvl >= 3'h2;
  assign #(LAG_NS) bat_above_recharge = lvl >= 3'h3;
  assign #(LAG_NS) bat_at_regulation = lvl >= 3'h4;
  assign #(LAG_NS) cur_below_term = taper;
  assign #(LAG_NS) ts_in_window = ts_ok && !ts_open;
  assign #(LAG_NS) ts_above_disable = ts_open;
endmodule
`default_nettype wire

// File: licc_pkg.sv
// Shared constants for the charge controller
package licc_pkg;
  // Register offsets
  localparam logic [3:0] CFG_ONE_OFS = 4'h0;
  localparam logic [3:0] TMR_CFG_OFS = 4'h1;
  localparam logic [3:0] STATUS_OFS = 4'h2;
  localparam logic [3:0] CUR_OFS = 4'h3;
  // charger_config_one field positions
  localparam int EN_BIT = 0;
  localparam int TERM_EN_BIT = 1;
  localparam int SCALE_LSB = 2;
  localparam int PRE_LSB = 4;
  localparam int TERM_LSB = 6;
  // charger_timer_config field positions
  localparam int PRE_TMR_LSB = 0;
  localparam int FAST_TMR_LSB = 4;
  localparam int SHIFT_LSB = 8;
  // Reset values
  localparam logic [7:0] CFG_ONE_RST = 8'h5E;
  localparam logic [9:0] TMR_CFG_RST = 10'h033;
  // Detection interval
  localparam int DET_INTERVAL_US = 250;
  localparam int CLK_MHZ = 200;
  localparam int DET_CYCLES = DET_INTERVAL_US * CLK_MHZ;
  // Base timer tick, one millisecond at nominal speed unit
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = TICK_MS * CLK_MHZ * 1000;
  // Charger phases
  typedef enum logic [3:0] {
    ST_IDLE, ST_SHORT, ST_PRE, ST_FAST, ST_CV, ST_DONE,
    ST_RM_TEST, ST_INS_SRC, ST_INS_SINK, ST_FAULT
  } licc_state_e;
endpackage

// File: licc_rate_timer.sv
// Safety timer whose tick rate follows the delivered charge fraction in ST_FAST only
`timescale 1ns/1ps
`default_nettype none
module licc_rate_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Control
  input wire logic clear,
  input wire logic run,
  input wire logic [7:0] rate,
  input wire logic [15:0] limit,
  // Result
  output logic expired
);
  logic [31:0] acc_ff;
  logic [15:0] cnt_ff;
  logic [31:0] nxt_acc;

  // Accumulate rate per cycle; one unit per tick-cycles at rate 64
  always_comb
  begin
    nxt_acc = acc_ff + {24'h000000, rate};
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      acc_ff <= 32'h0;
      cnt_ff <= 16'h0;
    end
    else if (clear)
    begin
      acc_ff <= 32'h0;
      cnt_ff <= 16'h0;
    end
    else if (run && !expired)
    begin
      if (nxt_acc >= 32'(licc_pkg::TICK_CYCLES * 64))
      begin
        acc_ff <= nxt_acc - 32'(licc_pkg::TICK_CYCLES * 64);
        cnt_ff <= cnt_ff + 16'h1;
      end
      else
      begin
        acc_ff <= nxt_acc;
      end
    end
  end

  assign expired = (cnt_ff >= limit) && (limit != 16'h0);
endmodule
`default_nettype wire

// File: licc_sync.sv
// Two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
`default_nettype none
module licc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_ff <= '0;
      q <= '0;
    end
    else
    begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the charge controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin err_total++; $display("[ERR] %s exp=%0h got=%0h", nm, ex, got); end end
module tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic pwr = 1'b1, die_reg = 1'b0, die_off = 1'b0, die_hys = 1'b0, share = 1'b0;
  logic present = 1'b1, taper = 1'b0, ts_ok = 1'b1, ts_open = 1'b0;
  logic [2:0] vlvl = 3'h0;
  logic vin_low = 1'b0;
  wire logic [15:0] rdata;
  wire logic [7:0] cur_tgt, term_tgt;
  wire logic short_src, sink, src, cv, qin, qbat, ntc, active, fault;
  wire logic [1:0] shift;
  wire logic a_short, a_low, a_rch, a_reg, c_term, ts_win, ts_dis;
  int err_total = 0;
  int checks_done = 0;
  logic [15:0] rv;
  always #2.5 clk = ~clk;
  licc_pack_model pack (.present(present), .vlvl(vlvl), .taper(taper), .ts_ok(ts_ok),
    .ts_open(ts_open), .det_sink_en(sink), .det_src_en(src), .bat_above_short(a_short),
    .bat_above_low(a_low), .bat_above_recharge(a_rch), .bat_at_regulation(a_reg),
    .cur_below_term(c_term), .ts_in_window(ts_win), .ts_above_disable(ts_dis));
  licc_charger uut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(rdata), .input_power_good(pwr),
    .bat_above_short(a_short), .bat_above_low(a_low), .bat_above_recharge(a_rch),
    .bat_at_regulation(a_reg), .cur_below_term(c_term), .ts_in_window(ts_win),
    .ts_above_disable(ts_dis), .die_above_reg(die_reg), .die_above_off(die_off),
    .die_below_off_hys(die_hys), .sharing_limit(share), .vin_low_limit(vin_low),
    .delivered_frac(7'h40), .charge_cur_target_ff(cur_tgt), .term_cur_target_ff(term_tgt),
    .short_test_src_ff(short_src), .det_sink_en_ff(sink), .det_src_en_ff(src),
    .cv_mode_ff(cv), .input_path_switch_ff(qin), .battery_path_switch_ff(qbat),
    .ntc_bias_en_ff(ntc), .pack_temp_limit_shift_ff(shift),
    .charging_active_flag_ff(active), .charger_fault_flag_ff(fault));
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rv = rdata;
  endtask
  task automatic settle;
    repeat (10) @(posedge clk);
    #1;
  endtask
  task automatic final_report;
    if (err_total == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge clk);
    err_total++;
    final_report();
  end
  initial
  begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    rd(licc_pkg::CFG_ONE_OFS);
    `CHK("cfg_rst", {8'h00, licc_pkg::CFG_ONE_RST}, rv)
    rd(licc_pkg::TMR_CFG_OFS);
    `CHK("tmr_rst", {6'h00, licc_pkg::TMR_CFG_RST}, rv)
    wr(4'h9, 16'hFFFF);
    rd(4'h9);
    `CHK("unmapped", 16'h0000, rv)
    wr(licc_pkg::TMR_CFG_OFS, 16'hF233);
    rd(licc_pkg::TMR_CFG_OFS);
    `CHK("tmr_wr", 16'h0233, rv)
    settle();
    `CHK("shift", 2'h2, shift)
    // Termination off: enable with short on the pin
    wr(licc_pkg::CFG_ONE_OFS, 16'h005D);
    settle();
    `CHK("short_src", 1'b1, short_src)
    `CHK("active", 1'b0, active)
    @(posedge clk) vlvl <= 3'h1;
    settle();
    `CHK("active", 1'b1, active)
    `CHK("pre_cur", 8'h20, cur_tgt)
    `CHK("ntc", 1'b1, ntc)
    @(posedge clk) share <= 1'b1;
    settle();
    `CHK("pre_cur", 8'h10, cur_tgt)
    `CHK("term_cur", 8'h08, term_tgt)
    @(posedge clk) share <= 1'b0;
    vlvl <= 3'h2;
    settle();
    `CHK("fast_cur", 8'h80, cur_tgt)
    @(posedge clk) vin_low <= 1'b1;
    settle();
    `CHK("fast_cur", 8'h40, cur_tgt)
    @(posedge clk) vin_low <= 1'b0;
    vlvl <= 3'h4;
    ts_ok <= 1'b0;
    ts_open <= 1'b1;
    settle();
    rd(licc_pkg::STATUS_OFS);
    `CHK("suspend", 1'b0, rv[6])
    `CHK("ntc", 1'b0, ntc)
    `CHK("cv", 1'b1, cv)
    @(posedge clk) ts_ok <= 1'b1;
    ts_open <= 1'b0;
    taper <= 1'b1;
    settle();
    `CHK("active", 1'b0, active)
    @(posedge clk) vlvl <= 3'h2;
    settle();
    `CHK("cv", 1'b1, cv)
    `CHK("sink", 1'b0, sink)
    @(posedge clk) pwr <= 1'b0;
    settle();
    @(posedge clk) pwr <= 1'b1;
    taper <= 1'b0;
    vlvl <= 3'h0;
    wr(licc_pkg::CFG_ONE_OFS, 16'h005E);
    // Termination on: suspend, thermal, detection
    wr(licc_pkg::CFG_ONE_OFS, 16'h005F);
    @(posedge clk) vlvl <= 3'h1;
    settle();
    @(posedge clk) ts_ok <= 1'b0;
    settle();
    rd(licc_pkg::STATUS_OFS);
    `CHK("suspend", 1'b1, rv[6])
    `CHK("active", 1'b1, active)
    @(posedge clk) ts_ok <= 1'b1;
    die_reg <= 1'b1;
    settle();
    rd(licc_pkg::STATUS_OFS);
    `CHK("suspend", 1'b0, rv[6])
    `CHK("pre_cur", 8'h10, cur_tgt)
    @(posedge clk) die_off <= 1'b1;
    settle();
    `CHK("qin", 1'b0, qin)
    `CHK("qbat", 1'b1, qbat)
    @(posedge clk) die_off <= 1'b0;
    die_hys <= 1'b1;
    settle();
    `CHK("qin", 1'b1, qin)
    @(posedge clk) die_hys <= 1'b0;
    die_reg <= 1'b0;
    vlvl <= 3'h4;
    taper <= 1'b1;
    settle();
    `CHK("active", 1'b0, active)
    @(posedge clk) vlvl <= 3'h2;
    settle();
    `CHK("sink", 1'b1, sink)
    @(posedge clk) taper <= 1'b0;
    repeat (licc_pkg::DET_CYCLES) @(posedge clk);
    settle();
    `CHK("sink", 1'b0, sink)
    `CHK("src", 1'b0, src)
    `CHK("active", 1'b0, active)
    `CHK("fault", 1'b0, fault)
    final_report();
  end
endmodule
bind licc_charger licc_monitor u_mon (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
  .die_above_off(die_above_off), .term_cur_target_ff(term_cur_target_ff),
  .short_test_src_ff(short_test_src_ff), .det_sink_en_ff(det_sink_en_ff),
  .det_src_en_ff(det_src_en_ff), .cv_mode_ff(cv_mode_ff),
  .input_path_switch_ff(input_path_switch_ff), .battery_path_switch_ff(battery_path_switch_ff),
  .pack_temp_limit_shift_ff(pack_temp_limit_shift_ff),
  .charging_active_flag_ff(charging_active_flag_ff));
`default_nettype wire
